/* File: src/rmc_pkg.sv */
// Constants, register map and state encodings for the radio mode control registers
package rmc_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] REV_ID_ADDR = 6'h00;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 6'h03;

    // Revision identification field layout
    localparam int DIE_REV_MSB = 7;
    localparam int DIE_REV_LSB = 4;
    localparam int PART_TYPE_MSB = 3;
    localparam int PART_TYPE_LSB = 0;

    // Die revision counts up from zero; this value is arbitrary
    localparam logic [3:0] DIE_REV_DEFAULT = 4'h2;
    // Arbitrary neutral part type code
    localparam logic [3:0] PART_TYPE_DEFAULT = 4'h5;

    // Control register field positions
    localparam int CTRL_RX_BIT = 7;
    localparam int CTRL_TX_BIT = 6;
    localparam int CTRL_HALF_BIT = 5;
    localparam int CTRL_BYPASS_BIT = 4;
    localparam int CTRL_PA_MANUAL_BIT = 3;
    localparam int CTRL_PA_ON_BIT = 2;

    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    // Bits 1:0 are reserved and never stored
    localparam logic [DATA_W-1:0] CTRL_WMASK = 8'hfc;
    localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;

    // Settle delay timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SETTLE_UNIT_NS = 2000;
    localparam int SETTLE_UNIT_CYCLES = (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CNT_W = 8;
    localparam int SETTLE_PRE_W = 16;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT_LOCK = 4'h2,
        ST_COUNT = 4'h4,
        ST_DONE = 4'h8
    } rmc_settle_state_t;

endpackage : rmc_pkg

/* File: src/rmc_settle_timer.sv */
// Synthesizer settle sequencer: optional lock wait, then programmed delay
`timescale 1ns/10ps
module rmc_settle_timer #(
    parameter int UNIT_CYCLES = rmc_pkg::SETTLE_UNIT_CYCLES,
    parameter int CNT_W = rmc_pkg::SETTLE_CNT_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Sequence control
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic i_bypass_lock,
    input wire logic i_pll_locked,
    input wire logic [CNT_W-1:0] i_settle_count,
    // Status
    output logic o_settle_done,
    output logic o_busy
);

    localparam int PRE_W = rmc_pkg::SETTLE_PRE_W;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYCLES - 1);

    if (UNIT_CYCLES < 1 || UNIT_CYCLES > (1 << PRE_W)) begin : g_bad_unit
        $error("rmc_settle_timer: UNIT_CYCLES out of range");
    end
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
        $error("rmc_settle_timer: CNT_W out of range");
    end

    rmc_pkg::rmc_settle_state_t state_r;
    rmc_pkg::rmc_settle_state_t state_nxt;
    logic [PRE_W-1:0] pre_r;
    logic [PRE_W-1:0] pre_nxt;
    logic [CNT_W-1:0] units_r;
    logic [CNT_W-1:0] units_nxt;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        pre_nxt = pre_r;
        units_nxt = units_r;
        if (i_abort) begin
            state_nxt = rmc_pkg::ST_IDLE;
            pre_nxt = '0;
            units_nxt = '0;
        end else if (i_start) begin
            // Count is latched at start; later edits do not stretch a running wait
            pre_nxt = '0;
            units_nxt = i_settle_count;
            state_nxt = i_bypass_lock ? rmc_pkg::ST_COUNT : rmc_pkg::ST_WAIT_LOCK;
        end else begin
            unique case (state_r)
                rmc_pkg::ST_IDLE: begin
                    state_nxt = rmc_pkg::ST_IDLE;
                end
                rmc_pkg::ST_WAIT_LOCK: begin
                    if (i_pll_locked) begin
                        state_nxt = rmc_pkg::ST_COUNT;
                        pre_nxt = '0;
                    end
                end
                rmc_pkg::ST_COUNT: begin
                    if (units_r == '0) begin
                        state_nxt = rmc_pkg::ST_DONE;
                    end else if (pre_r == PRE_LAST) begin
                        pre_nxt = '0;
                        units_nxt = units_r - CNT_W'(1);
                    end else begin
                        pre_nxt = pre_r + PRE_W'(1);
                    end
                end
                rmc_pkg::ST_DONE: begin
                    state_nxt = rmc_pkg::ST_DONE;
                end
                default: begin
                    state_nxt = rmc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= rmc_pkg::ST_IDLE;
            pre_r <= '0;
            units_r <= '0;
        end else begin
            state_r <= state_nxt;
            pre_r <= pre_nxt;
            units_r <= units_nxt;
        end
    end

    assign o_settle_done = (state_r == rmc_pkg::ST_DONE);
    assign o_busy = (state_r == rmc_pkg::ST_WAIT_LOCK) || (state_r == rmc_pkg::ST_COUNT);

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_bypass_skips_lock: assert property (
        i_start && !i_abort && i_bypass_lock |=> state_r == rmc_pkg::ST_COUNT)
        else $error("bypass did not skip lock wait");

    a_lock_wait_holds: assert property (
        state_r == rmc_pkg::ST_WAIT_LOCK && !i_pll_locked && !i_abort && !i_start
        |=> state_r == rmc_pkg::ST_WAIT_LOCK)
        else $error("left lock wait without lock");

    a_unit_step: assert property (
        state_r == rmc_pkg::ST_COUNT && units_r != '0 && pre_r == PRE_LAST
        && !i_abort && !i_start |=> units_r == $past(units_r) - CNT_W'(1) && pre_r == '0)
        else $error("settle unit not counted at unit end");

    a_pre_bound: assert property (
        pre_r <= PRE_LAST)
        else $error("prescaler past unit length");

    c_lock_path: cover property (
        state_r == rmc_pkg::ST_WAIT_LOCK ##1 state_r == rmc_pkg::ST_COUNT);

endmodule : rmc_settle_timer

/* File: src/rmc_top.sv */
// Revision and radio control registers with mode, code half, amplifier and settle logic
`timescale 1ns/10ps
// What this block does
// - Revision register upper nibble reads the die revision, zero for first silicon.
// - Revision register lower nibble reads a fixed part type that writes cannot change.
// - Control bit 7 set enters receive mode; clear leaves it.
// - Control bit 6 set enters transmit mode; clear leaves it.
// - Control bit 5 picks upper (1) or lower (0) 32 chips of the code.
// - Half choice applies only with 32-chip codes; ignored with 64-chip codes.
// - Bit 4 set: settle skips lock indication, waits only programmed delay.
// - Bit 4 clear: settle waits for lock, then the programmed delay.
// - Programmed settle count is in units of 2 microseconds.
// - Bit 3 clear: baseband switches the power amplifier automatically.
// - Bit 3 set: amplifier is on exactly while bit 2 is one.
// - In automatic mode the manual amplifier enable bit is disregarded.
module rmc_top #(
    parameter logic [3:0] DIE_REVISION = rmc_pkg::DIE_REV_DEFAULT,
    parameter logic [3:0] PART_TYPE = rmc_pkg::PART_TYPE_DEFAULT,
    parameter int SETTLE_UNIT_CYCLES = rmc_pkg::SETTLE_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Register port from the serial front end
    input wire logic [rmc_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [rmc_pkg::DATA_W-1:0] i_reg_wdata,
    output logic [rmc_pkg::DATA_W-1:0] o_reg_rdata,
    // Radio context
    input wire logic i_code_width_32,
    input wire logic i_pll_locked,
    input wire logic [rmc_pkg::SETTLE_CNT_W-1:0] i_settle_count,
    input wire logic i_baseband_pa_on,
    // Radio controls
    output logic o_rx_mode,
    output logic o_tx_mode,
    output logic o_code_half_upper,
    output logic o_pa_on,
    output logic o_settle_done,
    output logic o_settle_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release synchroniser
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [rmc_pkg::DATA_W-1:0] ctrl_r;
    logic [rmc_pkg::DATA_W-1:0] ctrl_nxt;
    logic [rmc_pkg::DATA_W-1:0] rdata_r;
    logic [rmc_pkg::DATA_W-1:0] rdata_nxt;
    logic [rmc_pkg::DATA_W-1:0] rev_word;

    always_comb begin
        rev_word = '0;
        rev_word[rmc_pkg::DIE_REV_MSB:rmc_pkg::DIE_REV_LSB] = DIE_REVISION;
        rev_word[rmc_pkg::PART_TYPE_MSB:rmc_pkg::PART_TYPE_LSB] = PART_TYPE;
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        // Only the control offset is writable; revision writes fall through
        if (i_reg_wr && i_reg_addr == rmc_pkg::CTRL_ADDR) begin
            ctrl_nxt = i_reg_wdata & rmc_pkg::CTRL_WMASK;
        end
        rdata_nxt = rdata_r;
        if (i_reg_rd) begin
            if (i_reg_addr == rmc_pkg::REV_ID_ADDR) begin
                rdata_nxt = rev_word;
            end else if (i_reg_addr == rmc_pkg::CTRL_ADDR) begin
                rdata_nxt = ctrl_r;
            end else begin
                rdata_nxt = rmc_pkg::RDATA_UNMAPPED;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= rmc_pkg::CTRL_RESET;
            rdata_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_rx_mode = ctrl_r[rmc_pkg::CTRL_RX_BIT];
    assign o_tx_mode = ctrl_r[rmc_pkg::CTRL_TX_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Code half and amplifier steering, registered so outputs stay glitch free
    logic half_r;
    logic half_nxt;
    logic pa_r;
    logic pa_nxt;
    logic mode_prev_r;
    logic mode_prev_nxt;
    logic mode_any;

    assign mode_any = o_rx_mode | o_tx_mode;

    always_comb begin
        // 64-chip codes use the whole code, so the half choice is masked
        half_nxt = i_code_width_32 & ctrl_r[rmc_pkg::CTRL_HALF_BIT];
        if (ctrl_r[rmc_pkg::CTRL_PA_MANUAL_BIT]) begin
            pa_nxt = ctrl_r[rmc_pkg::CTRL_PA_ON_BIT];
        end else begin
            pa_nxt = i_baseband_pa_on;
        end
        mode_prev_nxt = mode_any;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            half_r <= 1'b0;
            pa_r <= 1'b0;
            mode_prev_r <= 1'b0;
        end else begin
            half_r <= half_nxt;
            pa_r <= pa_nxt;
            mode_prev_r <= mode_prev_nxt;
        end
    end

    assign o_code_half_upper = half_r;
    assign o_pa_on = pa_r;

    ////////////////////////////////////////////////////////////////////////////
    // Settle sequence restarts each time the radio leaves idle
    rmc_settle_timer #(
        .UNIT_CYCLES(SETTLE_UNIT_CYCLES),
        .CNT_W(rmc_pkg::SETTLE_CNT_W)
    ) u_settle (
        .i_clk(i_clk_sys),
        .i_rst_n(rst_n),
        .i_start(mode_any && !mode_prev_r),
        .i_abort(!mode_any),
        .i_bypass_lock(ctrl_r[rmc_pkg::CTRL_BYPASS_BIT]),
        .i_pll_locked(i_pll_locked),
        .i_settle_count(i_settle_count),
        .o_settle_done(o_settle_done),
        .o_busy(o_settle_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n);

    a_die_rev_read: assert property (
        i_reg_rd && i_reg_addr == rmc_pkg::REV_ID_ADDR
        |=> o_reg_rdata[rmc_pkg::DIE_REV_MSB:rmc_pkg::DIE_REV_LSB] == DIE_REVISION)
        else $error("die revision field wrong");

    a_part_type_read: assert property (
        i_reg_rd && i_reg_addr == rmc_pkg::REV_ID_ADDR
        |=> o_reg_rdata[rmc_pkg::PART_TYPE_MSB:rmc_pkg::PART_TYPE_LSB] == PART_TYPE)
        else $error("part type field wrong");

    a_rx_mode_write: assert property (
        i_reg_wr && i_reg_addr == rmc_pkg::CTRL_ADDR
        |=> o_rx_mode == $past(i_reg_wdata[rmc_pkg::CTRL_RX_BIT]))
        else $error("receive mode does not follow write");

    a_tx_mode_write: assert property (
        i_reg_wr && i_reg_addr == rmc_pkg::CTRL_ADDR
        |=> o_tx_mode == $past(i_reg_wdata[rmc_pkg::CTRL_TX_BIT]))
        else $error("transmit mode does not follow write");

    a_half_select: assert property (
        i_code_width_32 |=> o_code_half_upper == $past(ctrl_r[rmc_pkg::CTRL_HALF_BIT]))
        else $error("code half does not follow control");

    a_half_ignored: assert property (
        !i_code_width_32 |=> !o_code_half_upper)
        else $error("code half used with 64-chip codes");

    a_pa_auto: assert property (
        !ctrl_r[rmc_pkg::CTRL_PA_MANUAL_BIT] |=> o_pa_on == $past(i_baseband_pa_on))
        else $error("amplifier not under baseband control");

    a_pa_manual: assert property (
        ctrl_r[rmc_pkg::CTRL_PA_MANUAL_BIT]
        |=> o_pa_on == $past(ctrl_r[rmc_pkg::CTRL_PA_ON_BIT]))
        else $error("amplifier not following manual enable");

    a_pa_enable_ignored: assert property (
        !ctrl_r[rmc_pkg::CTRL_PA_MANUAL_BIT] && !i_baseband_pa_on
        && ctrl_r[rmc_pkg::CTRL_PA_ON_BIT] |=> !o_pa_on)
        else $error("manual enable leaked in automatic mode");

    a_rev_write_inert: assert property (
        i_reg_wr && i_reg_addr == rmc_pkg::REV_ID_ADDR |=> $stable(ctrl_r))
        else $error("revision write changed control");

    a_ctrl_reset: assert property (
        $rose(rst_n) |-> ctrl_r == rmc_pkg::CTRL_RESET)
        else $error("control not zero after reset");

    c_rx_entered: cover property ($rose(o_rx_mode));
    c_tx_entered: cover property ($rose(o_tx_mode));
    c_settle_done: cover property ($rose(o_settle_done));
    c_pa_manual_on: cover property (ctrl_r[rmc_pkg::CTRL_PA_MANUAL_BIT] && o_pa_on);

endmodule : rmc_top

/* File: testbench/rmc_host_model.sv */
// Host model driving the register port and the radio context inputs
`timescale 1ns/10ps
module rmc_host_model (
    // Clock
    input wire logic i_clk,
    // Register port
    output logic [rmc_pkg::ADDR_W-1:0] o_reg_addr,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [rmc_pkg::DATA_W-1:0] o_reg_wdata,
    // Radio context
    output logic o_code_width_32,
    output logic o_pll_locked,
    output logic [rmc_pkg::SETTLE_CNT_W-1:0] o_settle_count,
    output logic o_baseband_pa_on
);
    initial begin
        o_reg_addr = 6'h2a;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_wdata = 8'h5a;
        o_code_width_32 = 1'b0;
        o_pll_locked = 1'b0;
        o_settle_count = 8'h01;
        o_baseband_pa_on = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One strobe cycle; changes only just after an edge
    task automatic access(input logic [5:0] addr, input logic wr, input logic [7:0] data);
        @(posedge i_clk);
        #1;
        o_reg_addr = addr;
        o_reg_wdata = (addr == rmc_pkg::CTRL_ADDR) ? (data & 8'hfc) : data;
        o_reg_wr = wr;
        o_reg_rd = !wr;
        @(posedge i_clk);
        #1;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        // Released lines carry junk so a stale sample shows up
        o_reg_addr = ~o_reg_addr;
        o_reg_wdata = ~o_reg_wdata;
    endtask : access

    // Code width is the data-rate setting held by the host
    task automatic set_ctx(input logic cw, input logic lock, input logic [7:0] cnt,
                           input logic bb);
        o_code_width_32 = cw;
        o_pll_locked = lock;
        o_settle_count = cnt;
        o_baseband_pa_on = bb;
    endtask : set_ctx
endmodule : rmc_host_model

/* File: testbench/rmc_top_bench.sv */
// Self-checking bench for the radio mode control registers
`timescale 1ns/10ps
module rmc_top_bench;
    localparam int UNIT = 4;
    logic clk;
    logic nrst;
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic cw;
    logic lock;
    logic [7:0] cnt;
    logic bb;
    logic rx, tx, half, pa, done, busy;
    logic rd_seen;
    logic [7:0] exp_q[$];
    logic [31:0] seed;
    int fails;
    int n_tests;
    int cyc;

    rmc_top #(.SETTLE_UNIT_CYCLES(UNIT)) dut_u (
        .i_clk_sys(clk), .i_nrst(nrst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_code_width_32(cw), .i_pll_locked(lock),
        .i_settle_count(cnt), .i_baseband_pa_on(bb), .o_rx_mode(rx), .o_tx_mode(tx),
        .o_code_half_upper(half), .o_pa_on(pa), .o_settle_done(done), .o_settle_busy(busy));

    rmc_host_model host_u (
        .i_clk(clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata),
        .o_code_width_32(cw), .o_pll_locked(lock), .o_settle_count(cnt),
        .o_baseband_pa_on(bb));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    task automatic final_report;
        $display("counts: comparisons=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic do_read(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.access(a, 1'b0, 8'h00);
    endtask : do_read

    // Done may rise no earlier than lo edges and no later than hi edges
    task automatic wait_done(input int lo, input int hi);
        int k;
        k = 0;
        while (done !== 1'b1 && k <= hi) begin
            @(posedge clk);
            #1;
            k++;
        end
        check_bit("settle_window", 1'b1, (k >= lo) && (k <= hi));
    endtask : wait_done

    ////////////////////////////////////////////////////////////////////////////////
    // Read data lands on the read edge; look half a cycle later
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                check_byte("reg_rdata_unexpected", 8'h00, 8'hxx);
            end else begin
                check_byte("reg_rdata", exp_q.pop_front(), rdata);
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        logic [5:0] ua;
        seed = 32'h0000c804;
        fails = 0;
        n_tests = 0;
        cyc = 0;
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        // Reset state and identification
        check_bit("rx_after_reset", 1'b0, rx);
        do_read(rmc_pkg::CTRL_ADDR, 8'h00);
        do_read(rmc_pkg::REV_ID_ADDR, {rmc_pkg::DIE_REV_DEFAULT, rmc_pkg::PART_TYPE_DEFAULT});
        seed = xs(seed);
        host_u.access(rmc_pkg::REV_ID_ADDR, 1'b1, seed[7:0]);
        do_read(rmc_pkg::REV_ID_ADDR, {rmc_pkg::DIE_REV_DEFAULT, rmc_pkg::PART_TYPE_DEFAULT});
        seed = xs(seed);
        ua = (seed[5:0] == 6'h00 || seed[5:0] == 6'h03) ? (seed[5:0] | 6'h10) : seed[5:0];
        do_read(ua, rmc_pkg::RDATA_UNMAPPED);
        $display("test identification done");
        // Every half, width, amplifier mode and request combination
        for (int i = 0; i < 32; i++) begin
            seed = xs(seed);
            d = {seed[7:6], i[0], seed[4], i[1], i[2], seed[1:0]};
            host_u.set_ctx(i[3], seed[8], 8'h01, i[4]);
            host_u.access(rmc_pkg::CTRL_ADDR, 1'b1, d);
            check_bit("rx_mode", d[7], rx);
            check_bit("tx_mode", d[6], tx);
            @(posedge clk);
            #1;
            check_bit("code_half", d[5] & i[3], half);
            check_bit("pa_on", d[3] ? d[2] : i[4], pa);
            do_read(rmc_pkg::CTRL_ADDR, d & 8'hfc);
        end
        $display("test control fields done");
        // Bypassed lock: delay only
        host_u.access(rmc_pkg::CTRL_ADDR, 1'b1, 8'h00);
        host_u.set_ctx(1'b0, 1'b0, 8'h02, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        check_bit("done_idle", 1'b0, done);
        host_u.access(rmc_pkg::CTRL_ADDR, 1'b1, 8'h90);
        wait_done(2 * UNIT, 2 * UNIT + 5);
        host_u.access(rmc_pkg::CTRL_ADDR, 1'b1, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        check_bit("done_abort", 1'b0, done);
        $display("test bypass settle done");
        // Lock wait, then the recommended count
        host_u.set_ctx(1'b0, 1'b0, 8'h19, 1'b0);
        host_u.access(rmc_pkg::CTRL_ADDR, 1'b1, 8'h40);
        // Longer than the whole delay, so a skipped lock wait would show as done
        repeat (120) @(posedge clk);
        #1;
        check_bit("done_before_lock", 1'b0, done);
        check_bit("busy_before_lock", 1'b1, busy);
        host_u.set_ctx(1'b0, 1'b1, 8'h19, 1'b0);
        wait_done(25 * UNIT, 25 * UNIT + 6);
        $display("test lock settle done");
        // Mid-run reset must clear a nonzero control value
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check_bit("tx_after_rerun_reset", 1'b0, tx);
        check_bit("done_after_rerun_reset", 1'b0, done);
        do_read(rmc_pkg::CTRL_ADDR, 8'h00);
        $display("test mid-run reset done");
        repeat (3) @(posedge clk);
        final_report();
    end
endmodule : rmc_top_bench
